// file: design/trct_defines.vh
// trct_defines.vh: register offsets, field positions, reset values, timing
// assumes: included by bare name from the cadence timer design files
`ifndef TRCT_DEFINES_VH
`define TRCT_DEFINES_VH
// register indices (byte address = 4 * index)
`define TRCT_METER_CTRL 8'h23
`define TRCT_OSC1_ON_LO 8'h24
`define TRCT_OSC1_ON_HI 8'h25
`define TRCT_OSC1_OFF_LO 8'h26
`define TRCT_OSC1_OFF_HI 8'h27
`define TRCT_OSC2_ON_LO 8'h28
`define TRCT_OSC2_ON_HI 8'h29
`define TRCT_OSC2_OFF_LO 8'h2a
`define TRCT_OSC2_OFF_HI 8'h2b
`define TRCT_METER_ON_LO 8'h2c
`define TRCT_METER_ON_HI 8'h2d
`define TRCT_METER_OFF_LO 8'h2e
`define TRCT_METER_OFF_HI 8'h2f
`define TRCT_RING_ON_LO 8'h30
`define TRCT_RING_ON_HI 8'h31
`define TRCT_RING_OFF_LO 8'h32
`define TRCT_RING_OFF_HI 8'h33
`define TRCT_FSK_BUF 8'h34
// extra control registers for osc1, osc2, ringing cadence bits and fsk mode
`define TRCT_OSC1_CTRL 8'h40
`define TRCT_OSC2_CTRL 8'h41
`define TRCT_RING_CTRL 8'h42
`define TRCT_FSK_CTRL 8'h43
// control field positions
`define TRCT_BIT_STAT 7
`define TRCT_BIT_REFETCH 6
`define TRCT_BIT_ON_EN 4
`define TRCT_BIT_OFF_EN 3
`define TRCT_BIT_OSC_EN 2
`define TRCT_BIT_FSK_ON 6
`define TRCT_CTRL_MASK 8'h1c
`define TRCT_OSC1_MASK 8'h5c
`define TRCT_RESET_BYTE 8'h00
// timing: one duration count
`define TRCT_TICK_NS 125000
`define TRCT_CLK_NS 10
`define TRCT_TICK_CYCLES (`TRCT_TICK_NS / `TRCT_CLK_NS)
`endif

// file: design/trct_fifo.v
// trct_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes: single clock, async active-low reset
`timescale 1ns/1ps
module trct_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg out_full;
  wire push;
  wire pop;
  wire load;
  wire [AW:0] depth_w;
  assign depth_w = DEPTH[AW:0];
  assign o_in_ready = (count != depth_w);
  assign o_out_valid = out_full;
  assign push = i_in_valid && o_in_ready;
  assign pop = out_full && i_out_ready;
  // output register refills from storage whenever empty or drained
  assign load = (count != {(AW+1){1'b0}}) && (!out_full || pop);
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        o_out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !load)
        count <= count + 1'b1;
      else if (!push && load)
        count <= count - 1'b1;
      if (load)
        out_full <= 1'b1;
      else if (pop)
        out_full <= 1'b0;
    end
  end
endmodule

// file: design/trct_cadence.v
// trct_cadence.v: cadence timers for osc1, osc2, pulse meter and ringing
// assumes: classic wishbone master on i_ref_clk, 100 MHz, word registers
// How it works
// - meter control bit 7 shows meter output
// - meter bit 4 enables on-time timer
// - meter bit 3 enables off-time timer
// - meter bit 2 turns meter oscillator on
// - osc1 on time, two bytes, 125 us
// - osc1 off time, two bytes, 125 us
// - osc2 on time, two bytes, 125 us
// - osc2 off time, two bytes, 125 us
// - meter on time, two bytes, 125 us
// - meter off time, two bytes, 125 us
// - ring on time, two bytes, 125 us
// - ring off time, two bytes, 125 us
// - duration and fsk registers reset to zero
// - fsk bit buffered when fsk and refetch
// - osc1 stops after off unless refetch
`timescale 1ns/1ps
`include "trct_defines.vh"
module trct_cadence #(
  parameter TICK_CYCLES = `TRCT_TICK_CYCLES,
  parameter FIFO_DEPTH = 4
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  output wire [3:0] o_osc_active,
  input wire i_fsk_bit_take,
  output wire o_fsk_bit_valid,
  output wire o_fsk_bit
);
  // channel index: 0 osc1, 1 osc2, 2 meter, 3 ringing
  reg [7:0] ctrl [0:3];
  reg [15:0] on_dur [0:3];
  reg [15:0] off_dur [0:3];
  wire [3:0] active;
  wire [3:0] keep_going;
  reg fsk_buf;
  reg fsk_on;
  reg fsk_pend;
  reg [16:0] tick_cnt;
  reg tick;
  wire req;
  wire wr_now;
  wire [7:0] idx;
  wire [7:0] wbyte;
  wire fifo_ready;
  integer k;
  genvar g;

  // cadence states, one sequencer per channel
  localparam ST_IDLE = 2'b00;
  localparam ST_ON = 2'b01;
  localparam ST_OFF = 2'b10;
  localparam ST_STOP = 2'b11;

  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_now = req && i_wb_we && i_wb_sel[0];
  assign idx = i_wb_adr[9:2];
  assign wbyte = i_wb_dat[7:0];
  assign o_osc_active = active;
  // only osc1 may stop after one burst
  assign keep_going = {3'b111, ctrl[0][`TRCT_BIT_REFETCH]};

  // 125 us tick enable
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[16:0] - 17'h00001) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // register writes
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (k = 0; k < 4; k = k + 1) begin
        ctrl[k] <= `TRCT_RESET_BYTE;
        on_dur[k] <= 16'h0000;
        off_dur[k] <= 16'h0000;
      end
      fsk_buf <= 1'b0;
      fsk_on <= 1'b0;
      fsk_pend <= 1'b0;
    end else begin
      if (wr_now) begin
        case (idx)
          `TRCT_METER_CTRL:
            ctrl[2] <= wbyte & `TRCT_CTRL_MASK;
          `TRCT_OSC1_CTRL: ctrl[0] <= wbyte & `TRCT_OSC1_MASK;
          `TRCT_OSC2_CTRL: ctrl[1] <= wbyte & `TRCT_CTRL_MASK;
          `TRCT_RING_CTRL: ctrl[3] <= wbyte & `TRCT_CTRL_MASK;
          `TRCT_FSK_CTRL: fsk_on <= wbyte[`TRCT_BIT_FSK_ON];
          `TRCT_OSC1_ON_LO: on_dur[0][7:0] <= wbyte;
          `TRCT_OSC1_ON_HI: on_dur[0][15:8] <= wbyte;
          `TRCT_OSC1_OFF_LO: off_dur[0][7:0] <= wbyte;
          `TRCT_OSC1_OFF_HI: off_dur[0][15:8] <= wbyte;
          `TRCT_OSC2_ON_LO: on_dur[1][7:0] <= wbyte;
          `TRCT_OSC2_ON_HI: on_dur[1][15:8] <= wbyte;
          `TRCT_OSC2_OFF_LO: off_dur[1][7:0] <= wbyte;
          `TRCT_OSC2_OFF_HI: off_dur[1][15:8] <= wbyte;
          `TRCT_METER_ON_LO: on_dur[2][7:0] <= wbyte;
          `TRCT_METER_ON_HI: on_dur[2][15:8] <= wbyte;
          `TRCT_METER_OFF_LO: off_dur[2][7:0] <= wbyte;
          `TRCT_METER_OFF_HI: off_dur[2][15:8] <= wbyte;
          `TRCT_RING_ON_LO: on_dur[3][7:0] <= wbyte;
          `TRCT_RING_ON_HI: on_dur[3][15:8] <= wbyte;
          `TRCT_RING_OFF_LO: off_dur[3][7:0] <= wbyte;
          `TRCT_RING_OFF_HI: off_dur[3][15:8] <= wbyte;
          default: ;
        endcase
      end
      // fsk bit goes to the fifo only in fsk refetch mode
      if (wr_now && idx == `TRCT_FSK_BUF) begin
        fsk_buf <= wbyte[0];
        fsk_pend <= fsk_on && ctrl[0][`TRCT_BIT_REFETCH];
      end else if (fsk_pend && fifo_ready) begin
        fsk_pend <= 1'b0;
      end
    end
  end

  // cadence sequencers, one per channel
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      reg [1:0] state;
      reg [1:0] next_state;
      reg [15:0] tmr;
      reg [15:0] next_tmr;
      reg on_flag;
      wire osc_en;
      wire on_en;
      wire off_en;
      wire [15:0] on_len;
      wire [15:0] off_len;
      assign osc_en = ctrl[g][`TRCT_BIT_OSC_EN];
      assign on_en = ctrl[g][`TRCT_BIT_ON_EN];
      assign off_en = ctrl[g][`TRCT_BIT_OFF_EN];
      assign on_len = on_dur[g];
      assign off_len = off_dur[g];
      assign active[g] = on_flag;

      always @* begin
        next_state = state;
        next_tmr = tmr;
        case (state)
          ST_IDLE: begin
            // start of a burst: load the on period
            next_state = ST_ON;
            next_tmr = on_len;
          end
          ST_ON: begin
            // a cleared timer enable freezes the phase
            if (tick && on_en) begin
              if (tmr == 16'h0000) begin
                next_state = ST_OFF;
                next_tmr = off_len;
              end else begin
                next_tmr = tmr - 16'h0001;
              end
            end
          end
          ST_OFF: begin
            if (tick && off_en) begin
              if (tmr != 16'h0000) begin
                next_tmr = tmr - 16'h0001;
              end else if (keep_going[g]) begin
                next_state = ST_ON;
                next_tmr = on_len;
              end else begin
                next_state = ST_STOP;
              end
            end
          end
          ST_STOP: begin
            // held until the oscillator enable is cleared
            next_state = ST_STOP;
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
        if (!osc_en) begin
          next_state = ST_IDLE;
          next_tmr = 16'h0000;
        end
      end

      always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          state <= ST_IDLE;
          tmr <= 16'h0000;
          on_flag <= 1'b0;
        end else begin
          state <= next_state;
          tmr <= next_tmr;
          on_flag <= (next_state == ST_ON);
        end
      end
    end
  endgenerate

  // register reads and ack, one wait state free: ack the cycle after req
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= 32'h00000000;
      if (req && !i_wb_we) begin
        case (idx)
          `TRCT_METER_CTRL:
            o_wb_dat[7:0] <= {active[2], ctrl[2][6:0]};
          `TRCT_OSC1_CTRL: o_wb_dat[7:0] <= {active[0], ctrl[0][6:0]};
          `TRCT_OSC2_CTRL: o_wb_dat[7:0] <= {active[1], ctrl[1][6:0]};
          `TRCT_RING_CTRL: o_wb_dat[7:0] <= {active[3], ctrl[3][6:0]};
          `TRCT_FSK_CTRL: o_wb_dat[7:0] <= {1'b0, fsk_on, 6'h00};
          `TRCT_OSC1_ON_LO: o_wb_dat[7:0] <= on_dur[0][7:0];
          `TRCT_OSC1_ON_HI: o_wb_dat[7:0] <= on_dur[0][15:8];
          `TRCT_OSC1_OFF_LO: o_wb_dat[7:0] <= off_dur[0][7:0];
          `TRCT_OSC1_OFF_HI: o_wb_dat[7:0] <= off_dur[0][15:8];
          `TRCT_OSC2_ON_LO: o_wb_dat[7:0] <= on_dur[1][7:0];
          `TRCT_OSC2_ON_HI: o_wb_dat[7:0] <= on_dur[1][15:8];
          `TRCT_OSC2_OFF_LO: o_wb_dat[7:0] <= off_dur[1][7:0];
          `TRCT_OSC2_OFF_HI: o_wb_dat[7:0] <= off_dur[1][15:8];
          `TRCT_METER_ON_LO: o_wb_dat[7:0] <= on_dur[2][7:0];
          `TRCT_METER_ON_HI: o_wb_dat[7:0] <= on_dur[2][15:8];
          `TRCT_METER_OFF_LO: o_wb_dat[7:0] <= off_dur[2][7:0];
          `TRCT_METER_OFF_HI: o_wb_dat[7:0] <= off_dur[2][15:8];
          `TRCT_RING_ON_LO: o_wb_dat[7:0] <= on_dur[3][7:0];
          `TRCT_RING_ON_HI: o_wb_dat[7:0] <= on_dur[3][15:8];
          `TRCT_RING_OFF_LO: o_wb_dat[7:0] <= off_dur[3][7:0];
          `TRCT_RING_OFF_HI: o_wb_dat[7:0] <= off_dur[3][15:8];
          `TRCT_FSK_BUF: o_wb_dat[7:0] <= {7'h00, fsk_buf};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

  // buffered fsk bits toward the modulator
  trct_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(fsk_pend),
    .o_in_ready(fifo_ready),
    .i_in_data(fsk_buf),
    .o_out_valid(o_fsk_bit_valid),
    .i_out_ready(i_fsk_bit_take),
    .o_out_data(o_fsk_bit)
  );
endmodule

// file: tb/trct_cadence_assertions.sv
// port checker for the cadence timer block
// assumes: bound onto trct_cadence, one clock domain
`timescale 1ns/1ps
module trct_cadence_assertions (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire [3:0] o_osc_active,
  input wire i_fsk_bit_take,
  input wire o_fsk_bit_valid,
  input wire o_fsk_bit
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  AST_ACK_REQ: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acked");
  AST_DAT_UPPER: assert property (
    o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_METER_RSVD: assert property (
    o_wb_ack && $past(i_wb_adr[9:2]) == 8'h23
    |-> o_wb_dat[6:5] == 2'h0 && o_wb_dat[1:0] == 2'h0)
    else $error("meter reserved bits set");
  AST_FSK_RSVD: assert property (
    o_wb_ack && $past(i_wb_adr[9:2]) == 8'h34
    |-> o_wb_dat[7:1] == 7'h0)
    else $error("fsk reserved bits set");
  AST_METER_STAT: assert property (
    o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr[9:2]) == 8'h23
    |-> o_wb_dat[7] == $past(o_osc_active[2]))
    else $error("meter status mismatch");
  AST_FSK_HOLD: assert property (
    o_fsk_bit_valid && !i_fsk_bit_take
    |=> o_fsk_bit_valid && $stable(o_fsk_bit))
    else $error("fsk bit dropped");
  AST_RESET_IDLE: assert property ($rose(i_rst_b)
    |-> o_osc_active == 4'h0 && !o_fsk_bit_valid)
    else $error("outputs busy after reset");
endmodule

// file: tb/trct_fsk_sink.sv
// consumer of the fsk bit stream
// assumes: stalls while i_go is low
`timescale 1ns/1ps
module trct_fsk_sink (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_go,
  input wire i_valid,
  input wire i_bit,
  output logic o_take,
  output logic [7:0] o_got,
  output int o_cnt
);
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_take <= 1'b0;
      o_got <= 8'h00;
      o_cnt <= 0;
    end else begin
      o_take <= i_go;
      if (i_valid && o_take) begin
        o_got[o_cnt[2:0]] <= i_bit;
        o_cnt <= o_cnt + 1;
      end
    end
  end
endmodule

// file: tb/trct_cadence_tb_top.sv
// self-checking bench for the cadence timer block
// assumes: design, checker and fsk sink compiled first
`timescale 1ns/1ps
module trct_cadence_tb_top;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, go = 0;
  logic [9:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0;
  logic [7:0] q;
  wire [31:0] rdat;
  wire ack, fvalid, fbit, take;
  wire [3:0] act;
  wire [7:0] got;
  int cnt, n_on, n_off, mismatches = 0, checked = 0;
  trct_cadence #(.TICK_CYCLES(10)) dut (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_osc_active(act), .i_fsk_bit_take(take), .o_fsk_bit_valid(fvalid),
    .o_fsk_bit(fbit));
  trct_fsk_sink sink (.i_ref_clk(clk), .i_rst_b(rst_b), .i_go(go),
    .i_valid(fvalid), .i_bit(fbit), .o_take(take), .o_got(got), .o_cnt(cnt));
  initial forever #5 clk = ~clk;
  task chk(input string what, input logic [15:0] exp, input logic [15:0] v);
    checked++;
    if (v !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, v);
    end
  endtask
  task chk_in(input string what, input int lo, input int hi, input int v);
    checked++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, idx, 2'b00, 4'hf, 24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    r = rdat[7:0];
    {cyc, stb} <= 2'b00;
    chk("ack latency", 16'd2, n[15:0]);
  endtask
  task span(input int b, input logic lvl, output int n);
    n = 0;
    while (act[b] === lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task t_regs;
    for (int a = 8'h23; a <= 8'h34; a++) begin
      wb(0, a[7:0], 8'h00, q);
      chk("reset value", 16'h0, q);
    end
    for (int a = 8'h24; a <= 8'h33; a++) wb(1, a[7:0], a[7:0] ^ 8'ha5, q);
    for (int a = 8'h24; a <= 8'h33; a++) begin
      wb(0, a[7:0], 8'h00, q);
      chk("duration byte", a[7:0] ^ 8'ha5, q);
    end
    wb(1, 8'h34, 8'hff, q);
    wb(0, 8'h34, 8'h00, q);
    chk("fsk byte", 16'h1, q);
    chk("fsk idle", 16'h0, fvalid);
    wb(1, 8'h23, 8'hfb, q);
    wb(0, 8'h23, 8'h00, q);
    chk("meter control", 16'h18, q);
    wb(1, 8'h00, 8'hff, q);
    wb(0, 8'h00, 8'h00, q);
    chk("unmapped", 16'h0, q);
  endtask
  // on count 3 (four ticks), off count 1 (two ticks), then freeze each phase
  task cadence(input logic [7:0] ctl, input logic [7:0] lo, input int b);
    wb(1, lo, 8'h03, q);
    wb(1, lo + 8'h1, 8'h00, q);
    wb(1, lo + 8'h2, 8'h01, q);
    wb(1, lo + 8'h3, 8'h00, q);
    wb(1, ctl, 8'h1c, q);
    span(b, 0, n_on);
    span(b, 1, n_on);
    span(b, 0, n_off);
    chk_in("on span", 31, 50, n_on);
    chk_in("off span", 11, 30, n_off);
    wb(0, ctl, 8'h00, q);
    chk("control status", 16'h9c, q);
    wb(1, ctl, 8'h0c, q);
    repeat (100) @(posedge clk);
    chk("on frozen", 16'h1, act[b]);
    wb(1, ctl, 8'h00, q);
    repeat (3) @(posedge clk);
    chk("disabled", 16'h0, act[b]);
    wb(1, ctl, 8'h14, q);
    span(b, 0, n_off);
    span(b, 1, n_on);
    repeat (100) @(posedge clk);
    chk("off frozen", 16'h0, act[b]);
    wb(1, ctl, 8'h00, q);
  endtask
  task osc1_bursts(input logic [7:0] c, output int r);
    logic p;
    r = 0;
    p = 1'b0;
    wb(1, 8'h40, c, q);
    repeat (200) begin
      @(posedge clk);
      if (act[0] === 1'b1 && p !== 1'b1) r++;
      p = act[0];
    end
    wb(1, 8'h40, 8'h00, q);
  endtask
  // six bits while stalled: four queued, one held, one pending
  task t_fsk;
    logic [7:0] bits;
    bits = 8'h2d;
    wb(1, 8'h43, 8'h40, q);
    wb(1, 8'h40, 8'h40, q);
    for (int i = 0; i < 6; i++) begin
      wb(1, 8'h34, {7'h0, bits[i]}, q);
      repeat (4) @(posedge clk);
    end
    chk("fsk head", {15'h0, bits[0]}, fbit);
    go <= 1'b1;
    repeat (30) @(posedge clk);
    chk("fsk count", 16'd6, cnt[15:0]);
    chk("fsk bits", {10'h0, bits[5:0]}, {10'h0, got[5:0]});
    // refetch off: a written bit must not reach the stream
    wb(1, 8'h40, 8'h00, q);
    wb(1, 8'h34, 8'h01, q);
    repeat (8) @(posedge clk);
    chk("fsk refetch off", 16'd6, cnt[15:0]);
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    cadence(8'h23, 8'h2c, 2);
    cadence(8'h41, 8'h28, 1);
    cadence(8'h42, 8'h30, 3);
    wb(1, 8'h24, 8'h01, q);
    wb(1, 8'h25, 8'h00, q);
    wb(1, 8'h26, 8'h01, q);
    wb(1, 8'h27, 8'h00, q);
    osc1_bursts(8'h1c, n_on);
    chk("osc1 single burst", 16'h1, n_on[15:0]);
    osc1_bursts(8'h5c, n_on);
    chk_in("osc1 repeated bursts", 2, 10, n_on);
    t_fsk;
    complete_run;
  end
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end
endmodule
bind trct_cadence trct_cadence_assertions u_chk (.i_ref_clk, .i_rst_b,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .o_osc_active, .i_fsk_bit_take, .o_fsk_bit_valid,
  .o_fsk_bit);
